// ===== design/sra_pkg.sv
/*
 * Shared constants and types of the serial rate search block.
 * Assumes a 32-bit classic Wishbone register bus and one system clock.
 */
package sra_pkg;

  localparam int NCH = 2;
  localparam int NCAND = 8;
  localparam int DWELL_W = 21;
  localparam int PRE_W = 10;
  localparam int ADR_W = 8;

  // Register word indices; the byte address is four times the index, plus 0x40 for channel B.
  localparam logic [3:0] IDX_RATE = 4'h1;
  localparam logic [3:0] IDX_STAT = 4'h5;
  localparam logic [3:0] IDX_CTRL = 4'ha;
  localparam logic [3:0] IDX_CFG = 4'hb;
  localparam logic [3:0] IDX_DWELL = 4'hc;
  localparam int CH_ADR_BIT = 6;

  // Field positions.
  localparam int CTRL_EN_LO = 12;
  localparam int CTRL_REFVAL = 0;
  localparam int CTRL_REFREG = 1;
  localparam int CTRL_LOSRT = 2;
  localparam int CTRL_FIFOF = 3;
  localparam int STAT_FOUND = 10;
  localparam int STAT_SYNC = 0;
  localparam int CFG_FREQ_LO = 14;
  localparam int CFG_MASK_LO = 6;

  // Reference frequency select codes.
  localparam logic [1:0] REF_122 = 2'h0;
  localparam logic [1:0] REF_153 = 2'h1;
  localparam logic [1:0] REF_307 = 2'h2;

  // Rate divider codes.
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUART = 2'h2;
  localparam logic [1:0] RATE_EIGHTH = 2'h3;

  // Multiplier codes.
  localparam logic [3:0] MC_8 = 4'h0;
  localparam logic [3:0] MC_10 = 4'h1;
  localparam logic [3:0] MC_16 = 4'h2;
  localparam logic [3:0] MC_20 = 4'h3;
  localparam logic [3:0] MC_25 = 4'h4;

  // Rate pin codes.
  localparam logic [2:0] PIN_SW = 3'h4;

  // Reset values.
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CFG_RST = 16'h3fc0;
  localparam logic [15:0] DWELL_RST = 16'h0100;
  localparam logic [7:0] RATE_RST = 8'h03;

  // Sync thresholds: commas to acquire, errors to lose, run to forgive.
  localparam logic [1:0] SY_COMMAS = 2'h2;
  localparam logic [1:0] SY_BAD = 2'h3;
  localparam logic [1:0] SY_GOOD = 2'h3;

  typedef struct packed {
    logic cdrLock;
    logic symValid;
    logic comma;
    logic dispErr;
  } sra_rx_t;

  typedef struct packed {
    logic [1:0] txRate;
    logic [1:0] rxRate;
    logic [3:0] mult;
  } sra_set_t;

  typedef enum {S_OFF, S_TRY, S_LOCK} sra_srch_t;

endpackage

// ===== design/sra_top.sv
/*
 * Two-channel serial rate search with its Wishbone register file.
 * Assumes the reference inputs arrive as one-cycle ticks synchronous
 * to clock, and decoder flags arrive per received symbol.
 */
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Only 122.88, 153.6, 307.2 MHz references supported.
// - Per-channel reference from pin or register.
// - Enable from field if pins 100, else pins.
// - Channels enable detection independently.
// - Only eight standard rates are searched.
// - Search overrides settings until disable, lock included.
// - Candidates tried highest to lowest, then wrap.
// - Eight-bit mask selects searched candidate rates.
// - After loss retry last rate once, continue down.
// - Commas and disparity errors drive sync machine.
// - Decoder used always; output format unchanged.
// - Sync requires CDR lock indication.
// - Locked: rate fields valid; unlocked: flag zero.
// - Inverted lock flag routable to loss output.
// - Dwell equals interval times 1024 reference periods.
// - Writes stored while searching; reads show applied.
// - Rate pairs map to eighth/quarter/half/full.
// - Multiplier chosen by reference and rate family.
// - Clock output fixed: 153.6 or 61.44 MHz.
// - Success resets FIFOs unless receive FIFO forced.
module sra_top (
  // System.
  input wire logic clock,
  input wire logic rst_n,
  // Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [sra_pkg::ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Reference period ticks.
  input wire logic refInputZeroTick,
  input wire logic refInputOneTick,
  // Per-channel pins.
  input wire logic chanARefsourcePin,
  input wire logic chanBRefsourcePin,
  input wire logic [2:0] ratePinsA,
  input wire logic [2:0] ratePinsB,
  input wire sra_pkg::sra_rx_t rxA,
  input wire sra_pkg::sra_rx_t rxB,
  input wire logic [1:0] losIn,
  // Per-channel results.
  output sra_pkg::sra_set_t setA,
  output sra_pkg::sra_set_t setB,
  output logic [1:0] speedFoundFlag,
  output logic [1:0] signalLossOutputs,
  output logic [1:0] fifoReset,
  output logic [1:0] clkOutTick
);

  localparam int N = sra_pkg::NCH;

  logic [15:0] ctrl_r [N];
  logic [15:0] cfg_r [N];
  logic [15:0] dwellLo_r [N];
  logic [7:0] prog_r [N];
  sra_pkg::sra_set_t set_r [N];
  sra_pkg::sra_srch_t st_r [N];
  logic [2:0] cand_r [N];
  logic [sra_pkg::PRE_W-1:0] pre_r [N];
  logic [sra_pkg::DWELL_W-1:0] dwell_r [N];
  logic [1:0] commaCnt_r [N];
  logic [1:0] badCnt_r [N];
  logic [1:0] goodCnt_r [N];
  logic [1:0] synced_r;
  logic [1:0] found_r;
  logic [1:0] loss_r;
  logic [1:0] fifoRst_r;
  logic [1:0] clkOut_r;
  logic [1:0] clkDiv_r;
  logic ack_r;
  logic [31:0] dat_r;

  sra_pkg::sra_rx_t rx [N];
  logic [2:0] pins [N];
  logic [1:0] refPin;
  logic [1:0] enabled;
  logic [1:0] tick;
  logic [1:0] expire;
  logic [1:0] restart;
  logic [1:0] refFreq [N];
  logic [7:0] mask [N];
  logic [20:0] interval [N];
  logic [2:0] nxtCand [N];

  logic req;
  logic chSel;
  logic [3:0] idx;
  logic mapped;
  logic wr;

  /////////////////////////////////////////////////////////////////////
  // Helpers.

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Highest enabled candidate below cur, else the highest enabled one.
  // An empty mask leaves the candidate where it is.
  function automatic logic [2:0] nextLower(input logic [7:0] m,
                                           input logic [2:0] cur);
    logic [2:0] r;
    logic hit;
    r = cur;
    hit = 1'b0;
    for (int i = 0; i < sra_pkg::NCAND; i++) begin
      if (m[i] && (3'(i) < cur)) begin
        r = 3'(i);
        hit = 1'b1;
      end
    end
    if (!hit) begin
      for (int i = 0; i < sra_pkg::NCAND; i++) begin
        if (m[i]) begin
          r = 3'(i);
        end
      end
    end
    return r;
  endfunction

  // Candidate index 7 is 6.144 Gbps, 0 is 0.6144 Gbps; odd indices are
  // the higher rate of each divider pair.
  function automatic sra_pkg::sra_set_t setFor(input logic [2:0] c,
                                               input logic [1:0] rf);
    sra_pkg::sra_set_t s;
    s.txRate = sra_pkg::RATE_FULL;
    unique case (c[2:1])
      2'h3: s.txRate = sra_pkg::RATE_FULL;
      2'h2: s.txRate = sra_pkg::RATE_HALF;
      2'h1: s.txRate = sra_pkg::RATE_QUART;
      2'h0: s.txRate = sra_pkg::RATE_EIGHTH;
    endcase
    s.rxRate = s.txRate;
    // Unsupported reference codes fall back to the 122.88 MHz loop.
    if (rf == sra_pkg::REF_153) begin
      s.mult = c[0] ? sra_pkg::MC_20 : sra_pkg::MC_16;
    end else if (rf == sra_pkg::REF_307) begin
      s.mult = c[0] ? sra_pkg::MC_10 : sra_pkg::MC_8;
    end else begin
      s.mult = c[0] ? sra_pkg::MC_25 : sra_pkg::MC_20;
    end
    return s;
  endfunction

  /////////////////////////////////////////////////////////////////////
  // Per-channel decode of configuration.

  assign rx[0] = rxA;
  assign rx[1] = rxB;
  assign pins[0] = ratePinsA;
  assign pins[1] = ratePinsB;
  assign refPin[0] = chanARefsourcePin;
  assign refPin[1] = chanBRefsourcePin;

  always_comb begin
    for (int c = 0; c < N; c++) begin
      refFreq[c] = cfg_r[c][sra_pkg::CFG_FREQ_LO +: 2];
      mask[c] = cfg_r[c][sra_pkg::CFG_MASK_LO +: 8];
      interval[c] = {cfg_r[c][4:0], dwellLo_r[c]};
      // Each channel decodes only its own pins and field.
      if (pins[c] == sra_pkg::PIN_SW) begin
        enabled[c] = |ctrl_r[c][sra_pkg::CTRL_EN_LO +: 2];
      end else begin
        enabled[c] = pins[c][2] & |pins[c][1:0];
      end
      if (ctrl_r[c][sra_pkg::CTRL_REFREG]) begin
        tick[c] = ctrl_r[c][sra_pkg::CTRL_REFVAL] ? refInputOneTick
                                                   : refInputZeroTick;
      end else begin
        tick[c] = refPin[c] ? refInputOneTick : refInputZeroTick;
      end
      expire[c] = (st_r[c] == sra_pkg::S_TRY) && tick[c] &&
                  (&pre_r[c]) && (dwell_r[c] <= 21'h000001);
      nxtCand[c] = nextLower(mask[c], cand_r[c]);
      restart[c] = !enabled[c] || expire[c];
    end
  end

  /////////////////////////////////////////////////////////////////////
  // Channel synchronisation from the decoder flags. The decoder runs
  // for the search even when the datapath bypasses it, so these flags
  // are always meaningful here.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      synced_r <= 2'h0;
      for (int c = 0; c < N; c++) begin
        commaCnt_r[c] <= 2'h0;
        badCnt_r[c] <= 2'h0;
        goodCnt_r[c] <= 2'h0;
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        if (!rx[c].cdrLock || restart[c]) begin
          synced_r[c] <= 1'b0;
          commaCnt_r[c] <= 2'h0;
          badCnt_r[c] <= 2'h0;
          goodCnt_r[c] <= 2'h0;
        end else if (rx[c].symValid && !synced_r[c]) begin
          if (rx[c].dispErr) begin
            commaCnt_r[c] <= 2'h0;
          end else if (rx[c].comma) begin
            if (commaCnt_r[c] == sra_pkg::SY_COMMAS) begin
              synced_r[c] <= 1'b1;
              badCnt_r[c] <= 2'h0;
              goodCnt_r[c] <= 2'h0;
            end else begin
              commaCnt_r[c] <= commaCnt_r[c] + 2'h1;
            end
          end
        end else if (rx[c].symValid) begin
          if (rx[c].dispErr) begin
            goodCnt_r[c] <= 2'h0;
            if (badCnt_r[c] == sra_pkg::SY_BAD) begin
              synced_r[c] <= 1'b0;
              commaCnt_r[c] <= 2'h0;
            end else begin
              badCnt_r[c] <= badCnt_r[c] + 2'h1;
            end
          end else if (badCnt_r[c] != 2'h0) begin
            // A run of good symbols forgives one earlier error.
            if (goodCnt_r[c] == sra_pkg::SY_GOOD) begin
              badCnt_r[c] <= badCnt_r[c] - 2'h1;
              goodCnt_r[c] <= 2'h0;
            end else begin
              goodCnt_r[c] <= goodCnt_r[c] + 2'h1;
            end
          end
        end
      end
    end
  end

  /////////////////////////////////////////////////////////////////////
  // Rate search.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      found_r <= 2'h0;
      fifoRst_r <= 2'h0;
      for (int c = 0; c < N; c++) begin
        st_r[c] <= sra_pkg::S_OFF;
        cand_r[c] <= 3'h7;
        pre_r[c] <= '0;
        dwell_r[c] <= '0;
      end
    end else begin
      fifoRst_r <= 2'h0;
      for (int c = 0; c < N; c++) begin
        if (!enabled[c]) begin
          st_r[c] <= sra_pkg::S_OFF;
          found_r[c] <= 1'b0;
        end else begin
          unique case (st_r[c])
            sra_pkg::S_OFF: begin
              st_r[c] <= sra_pkg::S_TRY;
              cand_r[c] <= nextLower(mask[c], 3'h0);
              pre_r[c] <= '0;
              dwell_r[c] <= interval[c];
            end
            sra_pkg::S_TRY: begin
              if (synced_r[c]) begin
                st_r[c] <= sra_pkg::S_LOCK;
                found_r[c] <= 1'b1;
                // Both FIFOs recentre unless receive is forced.
                fifoRst_r[c] <= !ctrl_r[c][sra_pkg::CTRL_FIFOF];
              end else if (expire[c]) begin
                cand_r[c] <= nxtCand[c];
                pre_r[c] <= '0;
                dwell_r[c] <= interval[c];
              end else if (tick[c]) begin
                pre_r[c] <= pre_r[c] + 1'b1;
                if (&pre_r[c]) begin
                  dwell_r[c] <= dwell_r[c] - 21'h000001;
                end
              end
            end
            sra_pkg::S_LOCK: begin
              if (!synced_r[c]) begin
                // Same candidate again for one dwell, then step down.
                st_r[c] <= sra_pkg::S_TRY;
                found_r[c] <= 1'b0;
                pre_r[c] <= '0;
                dwell_r[c] <= interval[c];
              end
            end
          endcase
        end
      end
    end
  end

  /////////////////////////////////////////////////////////////////////
  // Applied settings, loss routing and the output clock tick.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < N; c++) begin
        set_r[c] <= sra_pkg::sra_set_t'(sra_pkg::RATE_RST);
      end
    end else begin
      for (int c = 0; c < N; c++) begin
        if (enabled[c] && st_r[c] != sra_pkg::S_OFF) begin
          set_r[c] <= setFor(cand_r[c], refFreq[c]);
        end else begin
          set_r[c] <= sra_pkg::sra_set_t'(prog_r[c]);
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      loss_r <= 2'h0;
    end else begin
      for (int c = 0; c < N; c++) begin
        if (ctrl_r[c][sra_pkg::CTRL_LOSRT]) begin
          loss_r[c] <= !found_r[c];
        end else begin
          loss_r[c] <= losIn[c];
        end
      end
    end
  end

  // The output rate only depends on the reference, never on the
  // candidate, so a downstream cleaner sees a steady frequency.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clkOut_r <= 2'h0;
      clkDiv_r <= 2'h0;
    end else begin
      for (int c = 0; c < N; c++) begin
        clkOut_r[c] <= 1'b0;
        if (tick[c]) begin
          clkDiv_r[c] <= !clkDiv_r[c];
          if (refFreq[c] == sra_pkg::REF_153 || clkDiv_r[c]) begin
            clkOut_r[c] <= 1'b1;
          end
        end
      end
    end
  end

  /////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, unmapped reads return zero.

  assign req = cyc_i && stb_i && !ack_r;
  assign chSel = adr_i[sra_pkg::CH_ADR_BIT];
  assign idx = adr_i[5:2];
  assign mapped = !adr_i[7] && (idx == sra_pkg::IDX_RATE ||
                  idx == sra_pkg::IDX_STAT || idx == sra_pkg::IDX_CTRL ||
                  idx == sra_pkg::IDX_CFG || idx == sra_pkg::IDX_DWELL);
  assign wr = req && we_i && mapped;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
    end else begin
      ack_r <= req;
      dat_r <= 32'h00000000;
      if (req && !we_i && mapped) begin
        unique case (idx)
          sra_pkg::IDX_RATE: dat_r[7:0] <= set_r[chSel];
          sra_pkg::IDX_STAT: begin
            dat_r[sra_pkg::STAT_FOUND] <= found_r[chSel];
            dat_r[sra_pkg::STAT_SYNC] <= synced_r[chSel];
          end
          sra_pkg::IDX_CTRL: dat_r[15:0] <= ctrl_r[chSel];
          sra_pkg::IDX_CFG: dat_r[15:0] <= cfg_r[chSel];
          sra_pkg::IDX_DWELL: dat_r[15:0] <= dwellLo_r[chSel];
          default: dat_r <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < N; c++) begin
        ctrl_r[c] <= sra_pkg::CTRL_RST;
        cfg_r[c] <= sra_pkg::CFG_RST;
        dwellLo_r[c] <= sra_pkg::DWELL_RST;
        prog_r[c] <= sra_pkg::RATE_RST;
      end
    end else if (wr) begin
      unique case (idx)
        sra_pkg::IDX_RATE: begin
          // Stored always, applied only once the search is off.
          if (sel_i[0]) begin
            prog_r[chSel] <= dat_i[7:0];
          end
        end
        sra_pkg::IDX_CTRL:
          ctrl_r[chSel] <= merge16(ctrl_r[chSel], dat_i, sel_i);
        sra_pkg::IDX_CFG:
          cfg_r[chSel] <= merge16(cfg_r[chSel], dat_i, sel_i);
        sra_pkg::IDX_DWELL:
          dwellLo_r[chSel] <= merge16(dwellLo_r[chSel], dat_i, sel_i);
        default: begin
        end
      endcase
    end
  end

  /////////////////////////////////////////////////////////////////////
  // Outputs.

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign setA = set_r[0];
  assign setB = set_r[1];
  assign speedFoundFlag = found_r;
  assign signalLossOutputs = loss_r;
  assign fifoReset = fifoRst_r;
  assign clkOutTick = clkOut_r;

endmodule

`default_nettype wire

// ===== tb/sra_checker.sv
/*
 * Port-level assertions on channel A and the register bus of sra_top.
 * Assumes one clock domain and an active-low asynchronous reset.
 */
`timescale 1ns/100ps
`default_nettype none
module sra_checker (
  // System.
  input wire logic clock,
  input wire logic rst_n,
  // Bus.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic [31:0] dat_o,
  // Channel A.
  input wire logic [2:0] ratePinsA,
  input wire sra_pkg::sra_rx_t rxA,
  input wire sra_pkg::sra_set_t setA,
  input wire logic [1:0] speedFoundFlag,
  input wire logic [1:0] fifoReset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  a_dat_quiet: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
  a_fifo_on_lock: assert property (fifoReset[0] |->
    speedFoundFlag[0] && !$past(speedFoundFlag[0]))
    else $error("fifo reset not at lock");
  a_lock_needs_cdr: assert property ($rose(speedFoundFlag[0]) |->
    $past(rxA.cdrLock)) else $error("lock without cdr lock");
  a_found_holds: assert property (speedFoundFlag[0] &&
    $past(speedFoundFlag[0]) |-> $stable(setA))
    else $error("settings moved while locked");
  a_found_legal: assert property (speedFoundFlag[0] |->
    setA.txRate == setA.rxRate && setA.mult <= sra_pkg::MC_25)
    else $error("illegal locked settings");
  a_cdr_drop: assert property (speedFoundFlag[0] &&
    !rxA.cdrLock |-> ##[1:3] !speedFoundFlag[0])
    else $error("lock kept without cdr");
  a_off_clear: assert property (!ratePinsA[2] &&
    $past(!ratePinsA[2]) |-> !speedFoundFlag[0])
    else $error("lock while disabled");
endmodule
bind sra_top sra_checker sra_checker_inst (.clock, .rst_n, .cyc_i,
  .stb_i, .ack_o, .dat_o, .ratePinsA, .rxA, .setA, .speedFoundFlag,
  .fifoReset);
`default_nettype wire

// ===== tb/sra_link_model.sv
/*
 * Remote serial transmitter seen through the receive decoder flags.
 * Assumes one symbol per clock; the line only decodes at its own rate.
 */
`timescale 1ns/100ps
`default_nettype none
module sra_link_model #(
  parameter logic [7:0] WANT = 8'h01
) (
  // System.
  input wire logic clock,
  input wire logic rst_n,
  // Device side.
  input wire sra_pkg::sra_set_t setIn,
  input wire logic dropLock,
  output sra_pkg::sra_rx_t rx
);
  logic [1:0] ph_r;
  logic match;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= 2'h0;
    end else begin
      ph_r <= ph_r + 2'h1;
    end
  end
  // Only a standard rate is sent; a wrong setting sees garbage.
  assign match = (setIn == WANT);
  assign rx.cdrLock = match && !dropLock;
  assign rx.symValid = 1'b1;
  assign rx.comma = match && ph_r[0];
  assign rx.dispErr = !match && (ph_r != 2'h0);
endmodule
`default_nettype wire

// ===== tb/tb.sv
/*
 * Self-checking bench of sra_top with a link model per channel.
 * Assumes reference ticks every cycle and a 1024-tick dwell on channel A.
 */
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clock = 0, rst_n = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 8'h0;
  logic [31:0] dw = 32'h0, dr;
  logic [15:0] q;
  logic [2:0] pinsA = 3'h0, pinsB = 3'h0;
  logic [1:0] los = 2'h0, found, lossOut, fifoRst, clkOut;
  logic dropA = 0, dropB = 0, ack, refSelA = 0, refSelB = 1;
  logic [3:0] sel = 4'h3;
  sra_pkg::sra_rx_t rxA, rxB;
  sra_pkg::sra_set_t setA, setB;
  int err_count = 0, comparisons = 0;
  always #2 clock = ~clock;
  sra_top sra_top_inst (.clock(clock), .rst_n(rst_n), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dw),
    .dat_o(dr), .ack_o(ack), .refInputZeroTick(1'b1),
    .refInputOneTick(1'b1), .chanARefsourcePin(refSelA),
    .chanBRefsourcePin(refSelB), .ratePinsA(pinsA), .ratePinsB(pinsB),
    .rxA(rxA), .rxB(rxB), .losIn(los), .setA(setA), .setB(setB),
    .speedFoundFlag(found), .signalLossOutputs(lossOut),
    .fifoReset(fifoRst), .clkOutTick(clkOut));
  sra_link_model #(.WANT(8'hf3)) link_a_inst (.clock(clock),
    .rst_n(rst_n), .setIn(setA), .dropLock(dropA), .rx(rxA));
  sra_link_model #(.WANT(8'h01)) link_b_inst (.clock(clock),
    .rst_n(rst_n), .setIn(setB), .dropLock(dropB), .rx(rxB));
  //////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  // The request stands until ack is sampled high, then is released.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= {16'h0, d};
    do begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_count++;
      $display("FAIL %0t bus timeout", $time);
      report_and_stop;
    end
    q = dr[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic waitf(input int ch, input logic v, input int lim);
    int n;
    n = 0;
    while (found[ch] !== v) begin
      @(posedge clock);
      n++;
      if (n > lim) begin
        err_count++;
        $display("FAIL %0t lock wait timeout", $time);
        report_and_stop;
      end
    end
  endtask
  task automatic cnt(input int ch, input int exp);
    int n;
    n = 0;
    repeat (20) begin
      @(posedge clock);
      if (clkOut[ch] === 1'b1) n++;
    end
    chk(n[15:0], exp[15:0]);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic reset_values;
    logic [7:0] a [6] = '{8'h28, 8'h2c, 8'h30, 8'h04, 8'h14, 8'h08};
    logic [15:0] e [6] = '{16'h0, 16'h3fc0, 16'h0100, 16'h03, 16'h0, 16'h0};
    for (int i = 0; i < 6; i++) begin
      wb(1'b0, a[i], 16'h0);
      chk(q, e[i]);
    end
    chk({8'h0, setA}, 16'h03);
    cnt(0, 10);
    los <= 2'h1;
    repeat (3) @(posedge clock);
    chk({14'h0, lossOut}, 16'h1);
  endtask
  // Two candidates: the upper one fails, the lower one locks.
  task automatic search_a;
    wb(1'b1, 8'h2c, 16'h4280);
    wb(1'b1, 8'h30, 16'h0001);
    wb(1'b1, 8'h04, 16'h0051);
    pinsA <= 3'h4;
    wb(1'b1, 8'h28, 16'h1004);
    repeat (4) @(posedge clock);
    chk({8'h0, setA}, 16'ha3);
    cnt(0, 20);
    wb(1'b1, 8'h04, 16'h0000);
    wb(1'b0, 8'h04, 16'h0);
    chk(q, 16'ha3);
    chk({8'h0, setA}, 16'ha3);
    waitf(0, 1'b1, 2300);
    chk({8'h0, setA}, 16'hf3);
    wb(1'b0, 8'h14, 16'h0);
    chk(q & 16'h0400, 16'h0400);
    chk({15'h0, lossOut[0]}, 16'h0);
    dropA <= 1'b1;
    waitf(0, 1'b0, 10);
    repeat (500) @(posedge clock);
    chk({8'h0, setA}, 16'hf3);
    chk({15'h0, lossOut[0]}, 16'h1);
    repeat (700) @(posedge clock);
    chk({8'h0, setA}, 16'ha3);
    dropA <= 1'b0;
    wb(1'b1, 8'h28, 16'h0000);
    repeat (3) @(posedge clock);
    chk({8'h0, setA}, 16'h00);
    chk({15'h0, found[0]}, 16'h0);
  endtask
  // Pin-enabled channel B on the 307.2 reference, A left off.
  task automatic search_b;
    wb(1'b1, 8'h6c, 16'ha000);
    pinsB <= 3'h5;
    repeat (4) @(posedge clock);
    chk({8'h0, setB}, 16'h01);
    cnt(1, 10);
    waitf(1, 1'b1, 200);
    wb(1'b0, 8'h54, 16'h0);
    chk(q & 16'h0400, 16'h0400);
    chk({8'h0, setA}, 16'h00);
    chk({15'h0, found[0]}, 16'h0);
    pinsB <= 3'h0;
    repeat (3) @(posedge clock);
    chk({14'h0, found}, 16'h0);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    reset_values;
    search_a;
    search_b;
    report_and_stop;
  end
endmodule
`default_nettype wire
